/* File: common/mpb_pkg.sv */
/*
 Constants, register offsets, reset values and shared helpers of the port block.
 Assumes a single clock domain and a byte-wide register port driven by the CPU bus.
*/
// What this block does
// - Port 0: two latched pins, per-bit direction
// - Port 0 input pins get selectable pull-ups
// - Driven port 0 level change raises interrupt request
// - Port 1: eight input-only pins, no latch
// - Port 2: six latched pins, direction, pull-ups
// - Port 4: eight latched pins, direction, pull-ups
// - Reset puts every bidirectional pin in input
// - Port 5: eight open-drain pins, direction, no pull-up
// - Port 6: eight open-drain pins, direction, no pull-up
// - Port 7 output drives its latch value
// - Port 7 input: latch zero, read readback register
// - Port 8 input: latch zero, read readback register
// - Port 9 input: latch zero, read readback register
// - Port 10: eight output-only latched pins, unreadable
// - Direction registers take byte or single-bit writes
// - Direction registers reset to all ones
// - Pull-up only on input bits with select set
// - Pull-up select registers reset to zero
// - Ports 0, 2 and 4 to 6 read: latch if output, pin if input
package mpb_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_PORT0 = 8'h00;
    localparam logic [7:0] ADDR_PORT1 = 8'h01;
    localparam logic [7:0] ADDR_PORT2 = 8'h02;
    localparam logic [7:0] ADDR_PORT4 = 8'h04;
    localparam logic [7:0] ADDR_PORT5 = 8'h05;
    localparam logic [7:0] ADDR_PORT6 = 8'h06;
    localparam logic [7:0] ADDR_PORT7 = 8'h07;
    localparam logic [7:0] ADDR_PORT8 = 8'h08;
    localparam logic [7:0] ADDR_PORT9 = 8'h09;
    localparam logic [7:0] ADDR_PORT10 = 8'h0a;
    localparam logic [7:0] ADDR_DIR0 = 8'h20;
    localparam logic [7:0] ADDR_DIR2 = 8'h22;
    localparam logic [7:0] ADDR_DIR4 = 8'h24;
    localparam logic [7:0] ADDR_DIR5 = 8'h25;
    localparam logic [7:0] ADDR_DIR6 = 8'h26;
    localparam logic [7:0] ADDR_PU0 = 8'h30;
    localparam logic [7:0] ADDR_PU2 = 8'h32;
    localparam logic [7:0] ADDR_PU4 = 8'h34;
    localparam logic [7:0] ADDR_RB7 = 8'h47;
    localparam logic [7:0] ADDR_RB8 = 8'h48;
    localparam logic [7:0] ADDR_RB9 = 8'h49;

    // ----------------------------------------
    // Reset values and fixed fields
    // ----------------------------------------
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] PU_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] UNUSED_READ = 8'h00;
    // Unimplemented direction bits read as one
    localparam logic [5:0] DIR0_FILL = 6'h3f;
    localparam logic [1:0] DIR2_FILL = 2'h3;
    localparam logic [7:0] MASK_RES_NONE = 8'h00;

    // ----------------------------------------
    // Byte or single-bit write
    // ----------------------------------------
    function automatic logic [7:0] mpb_wr8(input logic [7:0] old, input logic [7:0] wd,
                                           input logic bit_mode, input logic [2:0] idx);
        logic [7:0] r;
        r = wd;
        if (bit_mode) begin
            r = old;
            r[idx] = wd[0];
        end
        return r;
    endfunction
endpackage

/* File: logic/mpb_bidir.sv */
/*
 Pin slice of a directly controlled bidirectional port, push-pull or N-channel open-drain.
 Assumes direction, latch and pull-up select come from registers of the parent.
*/
`timescale 1ns/100ps
`default_nettype none
module mpb_bidir #(
    parameter int W = 8,
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic [W-1:0] dir,
    input wire logic [W-1:0] lat,
    input wire logic [W-1:0] pusel,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pullup_en,
    output logic [W-1:0] rd_val
);
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    always_comb begin
        if (OPEN_DRAIN) begin
            // Open drain only pulls low; a high latch releases the pin
            pin_out = '0;
            pin_oe = ~dir & ~lat;
        end else begin
            pin_out = lat;
            pin_oe = ~dir;
        end
        pullup_en = dir & pusel;
        rd_val = (dir & pin_in) | (~dir & lat);
    end
endmodule
`default_nettype wire

/* File: logic/mpb_pch.sv */
/*
 Pin slice of a P-channel open-drain high-voltage port, steered by its latch alone.
 Assumes software clears a latch bit to use that pin as input.
*/
`timescale 1ns/100ps
`default_nettype none
module mpb_pch #(
    parameter int W = 8
) (
    input wire logic [W-1:0] lat,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] readback
);
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    always_comb begin
        // P-channel only pulls high; a zero latch leaves the pin free
        pin_out = lat;
        pin_oe = lat;
        readback = pin_in;
    end
endmodule
`default_nettype wire

/* File: logic/mpb_port_block.sv */
/*
 Top of the port block: output latches, direction and pull-up registers, read mux.
 Assumes a CPU register port with one-cycle strobes and pins synchronous to ref_clk.
*/
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module mpb_port_block #(
    parameter logic [7:0] P5_MASK_PULLUP = mpb_pkg::MASK_RES_NONE,
    parameter logic [7:0] P6_MASK_PULLUP = mpb_pkg::MASK_RES_NONE,
    parameter logic [7:0] P7_MASK_PULLDOWN = mpb_pkg::MASK_RES_NONE,
    parameter logic [7:0] P8_MASK_PULLDOWN = mpb_pkg::MASK_RES_NONE,
    parameter logic [7:0] P9_MASK_PULLDOWN = mpb_pkg::MASK_RES_NONE,
    parameter logic [7:0] P10_MASK_PULLDOWN = mpb_pkg::MASK_RES_NONE
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_bit_mode,
    input wire logic [2:0] reg_bit_idx,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] p0_pin_in,
    output logic [1:0] p0_pin_out,
    output logic [1:0] p0_pin_oe,
    output logic [1:0] p0_pullup_en,
    output logic [1:0] p0_level_chg,
    input wire logic [7:0] p1_pin_in,
    input wire logic [5:0] p2_pin_in,
    output logic [5:0] p2_pin_out,
    output logic [5:0] p2_pin_oe,
    output logic [5:0] p2_pullup_en,
    input wire logic [7:0] p4_pin_in,
    output logic [7:0] p4_pin_out,
    output logic [7:0] p4_pin_oe,
    output logic [7:0] p4_pullup_en,
    input wire logic [7:0] p5_pin_in,
    output logic [7:0] p5_pin_out,
    output logic [7:0] p5_pin_oe,
    output logic [7:0] p5_mask_pullup,
    input wire logic [7:0] p6_pin_in,
    output logic [7:0] p6_pin_out,
    output logic [7:0] p6_pin_oe,
    output logic [7:0] p6_mask_pullup,
    input wire logic [7:0] p7_pin_in,
    output logic [7:0] p7_pin_out,
    output logic [7:0] p7_pin_oe,
    output logic [7:0] p7_mask_pulldown,
    input wire logic [7:0] p8_pin_in,
    output logic [7:0] p8_pin_out,
    output logic [7:0] p8_pin_oe,
    output logic [7:0] p8_mask_pulldown,
    input wire logic [7:0] p9_pin_in,
    output logic [7:0] p9_pin_out,
    output logic [7:0] p9_pin_oe,
    output logic [7:0] p9_mask_pulldown,
    output logic [7:0] p10_pin_out,
    output logic [7:0] p10_pin_oe,
    output logic [7:0] p10_mask_pulldown
);
    import mpb_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] lat0;
        logic [5:0] lat2;
        logic [7:0] lat4;
        logic [7:0] lat5;
        logic [7:0] lat6;
        logic [7:0] lat7;
        logic [7:0] lat8;
        logic [7:0] lat9;
        logic [7:0] lat10;
        logic [1:0] dir0;
        logic [5:0] dir2;
        logic [7:0] dir4;
        logic [7:0] dir5;
        logic [7:0] dir6;
        logic [1:0] pu0;
        logic [5:0] pu2;
        logic [7:0] pu4;
        logic [7:0] rdata;
        logic [1:0] chg0;
    } mpb_state_t;

    mpb_state_t st_q;
    mpb_state_t st_d;

    logic [1:0] rd0;
    logic [5:0] rd2;
    logic [7:0] rd4;
    logic [7:0] rd5;
    logic [7:0] rd6;
    logic [7:0] rb7;
    logic [7:0] rb8;
    logic [7:0] rb9;
    logic [7:0] wv;

    // ----------------------------------------
    // Pin slices
    // ----------------------------------------
    mpb_bidir #(.W(2), .OPEN_DRAIN(1'b0)) u_p0 (
        .dir(st_q.dir0),
        .lat(st_q.lat0),
        .pusel(st_q.pu0),
        .pin_in(p0_pin_in),
        .pin_out(p0_pin_out),
        .pin_oe(p0_pin_oe),
        .pullup_en(p0_pullup_en),
        .rd_val(rd0)
    );

    mpb_bidir #(.W(6), .OPEN_DRAIN(1'b0)) u_p2 (
        .dir(st_q.dir2),
        .lat(st_q.lat2),
        .pusel(st_q.pu2),
        .pin_in(p2_pin_in),
        .pin_out(p2_pin_out),
        .pin_oe(p2_pin_oe),
        .pullup_en(p2_pullup_en),
        .rd_val(rd2)
    );

    mpb_bidir #(.W(8), .OPEN_DRAIN(1'b0)) u_p4 (
        .dir(st_q.dir4),
        .lat(st_q.lat4),
        .pusel(st_q.pu4),
        .pin_in(p4_pin_in),
        .pin_out(p4_pin_out),
        .pin_oe(p4_pin_oe),
        .pullup_en(p4_pullup_en),
        .rd_val(rd4)
    );

    // No software pull-up on the open-drain ports
    mpb_bidir #(.W(8), .OPEN_DRAIN(1'b1)) u_p5 (
        .dir(st_q.dir5),
        .lat(st_q.lat5),
        .pusel(PU_RESET),
        .pin_in(p5_pin_in),
        .pin_out(p5_pin_out),
        .pin_oe(p5_pin_oe),
        .pullup_en(),
        .rd_val(rd5)
    );

    mpb_bidir #(.W(8), .OPEN_DRAIN(1'b1)) u_p6 (
        .dir(st_q.dir6),
        .lat(st_q.lat6),
        .pusel(PU_RESET),
        .pin_in(p6_pin_in),
        .pin_out(p6_pin_out),
        .pin_oe(p6_pin_oe),
        .pullup_en(),
        .rd_val(rd6)
    );

    mpb_pch #(.W(8)) u_p7 (
        .lat(st_q.lat7),
        .pin_in(p7_pin_in),
        .pin_out(p7_pin_out),
        .pin_oe(p7_pin_oe),
        .readback(rb7)
    );

    mpb_pch #(.W(8)) u_p8 (
        .lat(st_q.lat8),
        .pin_in(p8_pin_in),
        .pin_out(p8_pin_out),
        .pin_oe(p8_pin_oe),
        .readback(rb8)
    );

    mpb_pch #(.W(8)) u_p9 (
        .lat(st_q.lat9),
        .pin_in(p9_pin_in),
        .pin_out(p9_pin_out),
        .pin_oe(p9_pin_oe),
        .readback(rb9)
    );

    // Output only: the readback is left open on purpose
    mpb_pch #(.W(8)) u_p10 (
        .lat(st_q.lat10),
        .pin_in(LATCH_RESET),
        .pin_out(p10_pin_out),
        .pin_oe(p10_pin_oe),
        .readback()
    );

    // ----------------------------------------
    // Static mask resistors
    // ----------------------------------------
    assign p5_mask_pullup = P5_MASK_PULLUP;
    assign p6_mask_pullup = P6_MASK_PULLUP;
    assign p7_mask_pulldown = P7_MASK_PULLDOWN;
    assign p8_mask_pulldown = P8_MASK_PULLDOWN;
    assign p9_mask_pulldown = P9_MASK_PULLDOWN;
    assign p10_mask_pulldown = P10_MASK_PULLDOWN;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        wv = UNUSED_READ;
        // Writes to the port latches, direction and pull-up registers
        if (reg_wr) begin
            if (reg_addr == ADDR_PORT0) begin
                wv = mpb_wr8({6'h00, st_q.lat0}, reg_wdata, reg_bit_mode, reg_bit_idx);
                st_d.lat0 = wv[1:0];
            end else if (reg_addr == ADDR_PORT2) begin
                wv = mpb_wr8({2'h0, st_q.lat2}, reg_wdata, reg_bit_mode, reg_bit_idx);
                st_d.lat2 = wv[5:0];
            end else if (reg_addr == ADDR_PORT4) begin
                st_d.lat4 = mpb_wr8(st_q.lat4, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_PORT5) begin
                st_d.lat5 = mpb_wr8(st_q.lat5, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_PORT6) begin
                st_d.lat6 = mpb_wr8(st_q.lat6, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_PORT7) begin
                st_d.lat7 = mpb_wr8(st_q.lat7, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_PORT8) begin
                st_d.lat8 = mpb_wr8(st_q.lat8, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_PORT9) begin
                st_d.lat9 = mpb_wr8(st_q.lat9, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_PORT10) begin
                st_d.lat10 = mpb_wr8(st_q.lat10, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_DIR0) begin
                wv = mpb_wr8({DIR0_FILL, st_q.dir0}, reg_wdata, reg_bit_mode, reg_bit_idx);
                st_d.dir0 = wv[1:0];
            end else if (reg_addr == ADDR_DIR2) begin
                wv = mpb_wr8({DIR2_FILL, st_q.dir2}, reg_wdata, reg_bit_mode, reg_bit_idx);
                st_d.dir2 = wv[5:0];
            end else if (reg_addr == ADDR_DIR4) begin
                st_d.dir4 = mpb_wr8(st_q.dir4, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_DIR5) begin
                st_d.dir5 = mpb_wr8(st_q.dir5, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_DIR6) begin
                st_d.dir6 = mpb_wr8(st_q.dir6, reg_wdata, reg_bit_mode, reg_bit_idx);
            end else if (reg_addr == ADDR_PU0) begin
                wv = mpb_wr8({6'h00, st_q.pu0}, reg_wdata, reg_bit_mode, reg_bit_idx);
                st_d.pu0 = wv[1:0];
            end else if (reg_addr == ADDR_PU2) begin
                wv = mpb_wr8({2'h0, st_q.pu2}, reg_wdata, reg_bit_mode, reg_bit_idx);
                st_d.pu2 = wv[5:0];
            end else if (reg_addr == ADDR_PU4) begin
                st_d.pu4 = mpb_wr8(st_q.pu4, reg_wdata, reg_bit_mode, reg_bit_idx);
            end
        end
        // Reads never touch a latch; data stands for one cycle only
        st_d.rdata = UNUSED_READ;
        if (reg_rd) begin
            if (reg_addr == ADDR_PORT0) begin
                st_d.rdata = {6'h00, rd0};
            end else if (reg_addr == ADDR_PORT1) begin
                st_d.rdata = p1_pin_in;
            end else if (reg_addr == ADDR_PORT2) begin
                st_d.rdata = {2'h0, rd2};
            end else if (reg_addr == ADDR_PORT4) begin
                st_d.rdata = rd4;
            end else if (reg_addr == ADDR_PORT5) begin
                st_d.rdata = rd5;
            end else if (reg_addr == ADDR_PORT6) begin
                st_d.rdata = rd6;
            end else if (reg_addr == ADDR_PORT7) begin
                st_d.rdata = st_q.lat7;
            end else if (reg_addr == ADDR_PORT8) begin
                st_d.rdata = st_q.lat8;
            end else if (reg_addr == ADDR_PORT9) begin
                st_d.rdata = st_q.lat9;
            end else if (reg_addr == ADDR_DIR0) begin
                st_d.rdata = {DIR0_FILL, st_q.dir0};
            end else if (reg_addr == ADDR_DIR2) begin
                st_d.rdata = {DIR2_FILL, st_q.dir2};
            end else if (reg_addr == ADDR_DIR4) begin
                st_d.rdata = st_q.dir4;
            end else if (reg_addr == ADDR_DIR5) begin
                st_d.rdata = st_q.dir5;
            end else if (reg_addr == ADDR_DIR6) begin
                st_d.rdata = st_q.dir6;
            end else if (reg_addr == ADDR_PU0) begin
                st_d.rdata = {6'h00, st_q.pu0};
            end else if (reg_addr == ADDR_PU2) begin
                st_d.rdata = {2'h0, st_q.pu2};
            end else if (reg_addr == ADDR_PU4) begin
                st_d.rdata = st_q.pu4;
            end else if (reg_addr == ADDR_RB7) begin
                st_d.rdata = rb7;
            end else if (reg_addr == ADDR_RB8) begin
                st_d.rdata = rb8;
            end else if (reg_addr == ADDR_RB9) begin
                st_d.rdata = rb9;
            end
        end
        // A driven pin feeds the interrupt input too, so a level flip is an edge there
        st_d.chg0 = ~st_q.dir0 & (st_d.lat0 ^ st_q.lat0);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.lat0 <= LATCH_RESET[1:0];
            st_q.lat2 <= LATCH_RESET[5:0];
            st_q.lat4 <= LATCH_RESET;
            st_q.lat5 <= LATCH_RESET;
            st_q.lat6 <= LATCH_RESET;
            st_q.lat7 <= LATCH_RESET;
            st_q.lat8 <= LATCH_RESET;
            st_q.lat9 <= LATCH_RESET;
            st_q.lat10 <= LATCH_RESET;
            st_q.dir0 <= DIR_RESET[1:0];
            st_q.dir2 <= DIR_RESET[5:0];
            st_q.dir4 <= DIR_RESET;
            st_q.dir5 <= DIR_RESET;
            st_q.dir6 <= DIR_RESET;
            st_q.pu0 <= PU_RESET[1:0];
            st_q.pu2 <= PU_RESET[5:0];
            st_q.pu4 <= PU_RESET;
            st_q.rdata <= UNUSED_READ;
            st_q.chg0 <= 2'h0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign p0_level_chg = st_q.chg0;
endmodule
`default_nettype wire

/* File: sim/mpb_port_block_asserts.sv */
/*
 Concurrent checks on the ports of the port block top.
 Assumes it is bound into mpb_port_block and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module mpb_port_block_asserts (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_bit_mode,
    input wire logic [2:0] reg_bit_idx,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] p0_pin_out,
    input wire logic [1:0] p0_pin_oe,
    input wire logic [1:0] p0_pullup_en,
    input wire logic [1:0] p0_level_chg,
    input wire logic [5:0] p2_pin_oe,
    input wire logic [5:0] p2_pullup_en,
    input wire logic [7:0] p4_pin_oe,
    input wire logic [7:0] p4_pullup_en,
    input wire logic [7:0] p5_pin_out,
    input wire logic [7:0] p5_pin_oe,
    input wire logic [7:0] p5_mask_pullup,
    input wire logic [7:0] p6_pin_out,
    input wire logic [7:0] p7_pin_out,
    input wire logic [7:0] p7_pin_oe,
    input wire logic [7:0] p10_pin_out
);
    import mpb_pkg::*;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_pull_out;
        ((p0_pullup_en & p0_pin_oe) == 2'h0) && ((p2_pullup_en & p2_pin_oe) == 6'h00)
            && ((p4_pullup_en & p4_pin_oe) == 8'h00);
    endproperty
    property p_dir4_byte;
        reg_wr && reg_addr == ADDR_DIR4 && !reg_bit_mode |=> p4_pin_oe == ~$past(reg_wdata);
    endproperty
    property p_dir2_bit;
        reg_wr && reg_addr == ADDR_DIR2 && reg_bit_mode && reg_bit_idx < 3'h6
            |=> p2_pin_oe[$past(reg_bit_idx)] == !$past(reg_wdata[0]);
    endproperty
    // Pulse only where the pin was driven before and after the edge
    property p_p0_chg;
        p0_level_chg == (p0_pin_oe & $past(p0_pin_oe) & (p0_pin_out ^ $past(p0_pin_out)));
    endproperty
    property p_od_low;
        p5_pin_out == 8'h00 && p6_pin_out == 8'h00;
    endproperty
    property p_pch;
        p7_pin_oe == p7_pin_out;
    endproperty
    property p_p10_wr;
        reg_wr && reg_addr == ADDR_PORT10 && !reg_bit_mode |=> p10_pin_out == $past(reg_wdata);
    endproperty
    property p_mask;
        $stable(p5_mask_pullup);
    endproperty
    property p_reset;
        $rose(rstn) |-> (p0_pin_oe | p0_pullup_en) == 2'h0 && p2_pin_oe == 6'h00
            && (p4_pin_oe | p5_pin_oe | p7_pin_oe | p4_pullup_en) == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read answer");
    a_pull_out: assert property (p_pull_out)
        else $error("pull-up on a driven pin");
    a_dir4_byte: assert property (p_dir4_byte)
        else $error("direction byte write not seen on enables");
    a_dir2_bit: assert property (p_dir2_bit)
        else $error("direction bit write not seen on enable");
    a_p0_chg: assert property (p_p0_chg)
        else $error("port zero change pulse wrong");
    a_od_low: assert property (p_od_low)
        else $error("open-drain pin drives high");
    a_pch: assert property (p_pch)
        else $error("high-voltage pin enable differs from level");
    a_p10_wr: assert property (p_p10_wr)
        else $error("output-only port does not show its latch");
    a_mask: assert property (p_mask)
        else $error("mask resistor setting moved");
    a_reset: assert property (p_reset)
        else $error("pins not released after reset");
    c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
    c_chg: cover property (p0_level_chg != 2'h0);
    c_bit: cover property (reg_wr && reg_bit_mode);
endmodule
`default_nettype wire

/* File: sim/test_mpb_port_block.sv */
/*
 Self-checking bench of the port block: register reads and writes with expected values.
 Assumes the bench alone drives every input of the block, pins included.
*/
`timescale 1ns/100ps
`default_nettype none
module test_mpb_port_block;
    import mpb_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, reg_bit_mode = 1'b0;
    logic [2:0] reg_bit_idx = 3'h0;
    logic [1:0] p0_pin_in = 2'h2, p0_pin_out, p0_pin_oe, p0_pullup_en, p0_level_chg;
    logic [5:0] p2_pin_in = 6'h15, p2_pin_out, p2_pin_oe, p2_pullup_en;
    logic [7:0] p1_pin_in = 8'h5e, p4_pin_in = 8'hc3, p4_pin_out, p4_pin_oe, p4_pullup_en;
    logic [7:0] p5_pin_in = 8'h96, p5_pin_out, p5_pin_oe, p5_mask_pullup;
    logic [7:0] p6_pin_in = 8'h69, p6_pin_out, p6_pin_oe, p6_mask_pullup;
    logic [7:0] p7_pin_in = 8'h3c, p7_pin_out, p7_pin_oe, p7_mask_pulldown;
    logic [7:0] p8_pin_in = 8'h3d, p8_pin_out, p8_pin_oe, p8_mask_pulldown;
    logic [7:0] p9_pin_in = 8'h3e, p9_pin_out, p9_pin_oe, p9_mask_pulldown;
    logic [7:0] p10_pin_out, p10_pin_oe, p10_mask_pulldown;
    int fails = 0, n_compared = 0;
    always #12.5 ref_clk = ~ref_clk;
    mpb_port_block #(.P5_MASK_PULLUP(8'h11), .P7_MASK_PULLDOWN(8'h22)) u_mpb_port_block (
        .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_bit_mode, .reg_bit_idx,
        .reg_rdata, .p0_pin_in, .p0_pin_out, .p0_pin_oe, .p0_pullup_en, .p0_level_chg,
        .p1_pin_in, .p2_pin_in, .p2_pin_out, .p2_pin_oe, .p2_pullup_en, .p4_pin_in,
        .p4_pin_out, .p4_pin_oe, .p4_pullup_en, .p5_pin_in, .p5_pin_out, .p5_pin_oe,
        .p5_mask_pullup, .p6_pin_in, .p6_pin_out, .p6_pin_oe, .p6_mask_pullup, .p7_pin_in,
        .p7_pin_out, .p7_pin_oe, .p7_mask_pulldown, .p8_pin_in, .p8_pin_out, .p8_pin_oe,
        .p8_mask_pulldown, .p9_pin_in, .p9_pin_out, .p9_pin_oe, .p9_mask_pulldown,
        .p10_pin_out, .p10_pin_oe, .p10_mask_pulldown);
    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bm = 1'b0,
                      input logic [2:0] ix = 3'h0);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_bit_mode <= bm;
        reg_bit_idx <= ix;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Data is taken in the one cycle after the strobe; it reads zero afterwards
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask
    task automatic reset_dut();
        rstn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    localparam logic [7:0] RA [8] = '{ADDR_DIR0, ADDR_DIR2, ADDR_DIR4, ADDR_DIR5, ADDR_DIR6,
                                      ADDR_PU0, ADDR_PU2, ADDR_PU4};
    initial begin
        reset_dut();
        for (int i = 0; i < 8; i++) rd(RA[i], (i < 5) ? 8'hff : 8'h00);
        chk("oe", 8'h00, {p0_pin_oe, p2_pin_oe} | p4_pin_oe | p5_pin_oe | p6_pin_oe);
        chk("oe hv", 8'h00, p7_pin_oe | p8_pin_oe | p9_pin_oe | p10_pin_oe);
        rd(ADDR_PORT0, 8'h02);
        rd(ADDR_PORT2, 8'h15);
        rd(ADDR_PORT5, 8'h96);
        rd(ADDR_PORT1, 8'h5e);
        p1_pin_in <= 8'ha1;
        wr(ADDR_PORT1, 8'hff);
        rd(ADDR_PORT1, 8'ha1);
        // Port 4: half driven, pull-ups asked on all bits
        wr(ADDR_PORT4, 8'h5a);
        wr(ADDR_DIR4, 8'h0f);
        wr(ADDR_PU4, 8'hff);
        chk("p4 oe", 8'hf0, p4_pin_oe);
        chk("p4 out", 8'h5a, p4_pin_out);
        chk("p4 pull", 8'h0f, p4_pullup_en);
        rd(ADDR_PORT4, 8'h53);
        wr(ADDR_DIR4, 8'h01, 1'b1, 3'h7);
        rd(ADDR_DIR4, 8'h8f);
        chk("p4 oe bit", 8'h70, p4_pin_oe);
        // Port 2: upper direction bits stay one, out-of-range bit write ignored
        wr(ADDR_PU2, 8'h3f);
        wr(ADDR_DIR2, 8'h2a);
        wr(ADDR_DIR2, 8'h00, 1'b1, 3'h6);
        rd(ADDR_DIR2, 8'hea);
        wr(ADDR_DIR2, 8'h01, 1'b1, 3'h0);
        chk("p2 oe", 8'h14, {2'h0, p2_pin_oe});
        chk("p2 pull", 8'h2b, {2'h0, p2_pullup_en});
        wr(ADDR_PORT2, 8'h23);
        chk("p2 out", 8'h23, {2'h0, p2_pin_out});
        rd(ADDR_PORT2, 8'h01);
        // Port 0: pull-ups dropped while driven, change pulse on driven bits only
        wr(ADDR_PU0, 8'h03);
        wr(ADDR_DIR0, 8'h00);
        chk("p0 pull", 8'h00, {6'h0, p0_pullup_en});
        rd(ADDR_DIR0, 8'hfc);
        wr(ADDR_PORT0, 8'h01);
        chk("p0 chg", 8'h01, {6'h0, p0_level_chg});
        chk("p0 out", 8'h01, {6'h0, p0_pin_out});
        @(posedge ref_clk) #1;
        chk("p0 chg end", 8'h00, {6'h0, p0_level_chg});
        wr(ADDR_DIR0, 8'h01);
        wr(ADDR_PORT0, 8'h02);
        chk("p0 chg mixed", 8'h02, {6'h0, p0_level_chg});
        chk("p0 pull in", 8'h01, {6'h0, p0_pullup_en});
        rd(ADDR_PORT0, 8'h02);
        // Open-drain ports 5 and 6
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_PORT5 + k[7:0], 8'h0f);
            wr(ADDR_DIR5 + k[7:0], 8'h00);
        end
        chk("p5 oe", 8'hf0, p5_pin_oe);
        chk("p6 oe", 8'hf0, p6_pin_oe);
        chk("od out", 8'h00, p5_pin_out | p6_pin_out);
        rd(ADDR_PORT6, 8'h0f);
        // High-voltage ports 7 to 9
        for (int k = 0; k < 3; k++) wr(ADDR_PORT7 + k[7:0], 8'h81);
        chk("hv oe", 8'h81, p7_pin_oe & p8_pin_oe & p9_pin_oe);
        chk("hv out", 8'h81, p7_pin_out | p8_pin_out | p9_pin_out);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_PORT7 + k[7:0], 8'h00);
            rd(ADDR_RB7 + k[7:0], 8'h3c + k[7:0]);
            rd(ADDR_PORT7 + k[7:0], 8'h00);
        end
        chk("hv oe off", 8'h00, p7_pin_oe | p8_pin_oe | p9_pin_oe);
        wr(ADDR_PORT10, 8'ha5);
        chk("p10 out", 8'ha5, p10_pin_out & p10_pin_oe);
        rd(ADDR_PORT10, 8'h00);
        wr(8'h7f, 8'hff);
        rd(8'h7f, 8'h00);
        chk("mask pu", 8'h11, p5_mask_pullup);
        chk("mask pd", 8'h22, p7_mask_pulldown | p10_mask_pulldown);
        chk("mask 0", 8'h00, p6_mask_pullup | p8_mask_pulldown | p9_mask_pulldown);
        reset_dut();
        chk("oe2", 8'h0, {p0_pin_oe, p2_pin_oe} | p4_pin_oe | p5_pin_oe | p10_pin_oe);
        rd(ADDR_DIR4, 8'hff);
        results();
    end
endmodule
bind mpb_port_block mpb_port_block_asserts u_mpb_port_block_asserts (
    .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_bit_mode, .reg_bit_idx,
    .reg_rdata, .p0_pin_out, .p0_pin_oe, .p0_pullup_en, .p0_level_chg, .p2_pin_oe,
    .p2_pullup_en, .p4_pin_oe, .p4_pullup_en, .p5_pin_out, .p5_pin_oe, .p5_mask_pullup,
    .p6_pin_out, .p7_pin_out, .p7_pin_oe, .p10_pin_out);
`default_nettype wire
